/* File: rtl/ass_pkg.sv */
// Package of constants and types shared by the scan sequencer and its result FIFO.
package ass_pkg;
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned CONV_TIME_US    = 10;
  localparam int unsigned CONV_CYCLES     = CONV_TIME_US * CLK_MHZ;
  localparam int unsigned FIFO_WIDTH      = 16;
  localparam int unsigned FIFO_DEPTH      = 512;
  localparam int unsigned RAW_WIDTH       = 12;
  localparam int unsigned CHAN_WIDTH      = 3;
  localparam int unsigned GAIN_WIDTH      = 3;
  localparam int unsigned TIMER_WIDTH     = 32;
  localparam int unsigned COUNT_WIDTH     = 16;
  localparam logic [2:0]  CHAN_LAST       = 3'h0;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [31:0] TIMER_RESET     = 32'h00000000;

  // Acquisition mode selected by software.
  typedef enum logic [1:0] {
    ASS_MODE_FREERUN    = 2'h0,
    ASS_MODE_CONTROLLED = 2'h1,
    ASS_MODE_INTERVAL   = 2'h2
  } ass_mode_type;
endpackage

/* File: rtl/ass_stream_if.sv */
// Valid/ready stream interface between the sequencer and the result FIFO.
`timescale 1ns/1ps
interface ass_stream_if #(
  parameter int WIDTH = 16
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

/* File: rtl/ass_fifo.sv */
// Result FIFO with valid/ready on both sides and honest full and empty.
`timescale 1ns/1ps
module ass_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 512
) (
  // Clock and reset.
  input  wire logic     sys_clk,
  input  wire logic     rst,
  // Write side.
  ass_stream_if.sink    wr,
  // Read side.
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic             full,
  output logic             empty
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } ass_fifo_state_type;

  ass_fifo_state_type s_q;
  ass_fifo_state_type s_d;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  // Data read straight from the array at the read pointer.
  assign full     = (s_q.cnt == (AW+1)'(DEPTH));
  assign empty    = (s_q.cnt == '0);
  assign wr.ready = !full;
  assign rd_valid = !empty;
  assign rd_data  = mem[s_q.rp];
  assign push     = wr.valid && !full;
  assign pop      = rd_ready && !empty;

  // Pointer and fill count update.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage is not reset; only pointers and fill count need a defined value.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[s_q.wp] <= wr.data;
    end
  end
endmodule

/* File: rtl/ass_sequencer.sv */
// Acquisition scan sequencer: interval timers, mux stepping and result path.
`timescale 1ns/1ps
// How it works
// [R1] Scan timer starts sequences, sample timer paces conversions.
// [R2] Whole sequence each scan interval, sample-spaced.
// [R3] First conversion one sample interval after pulse.
// [R4] Software keeps sample interval above conversion time.
// [R5] Interval scanning with single or multiple channels.
// [R6] Single channel converts per external or timer tick.
// [R7] Software fixes channel and gain beforehand.
// [R8] One common gain for all scanned channels.
// [R9] Start channel down to zero, then repeat.
// [R10] Software allows gain-dependent amplifier settling.
// [R11] Single channel may run at converter limit.
// [R12] Software keeps multichannel rate within limits.
// [R13] Fast multichannel scanning is never blocked.
// [R14] Results buffered in FIFO; overflow flagged.
// [R15] Sample counter stops conversions after count.
// [R16] Results sign-extended by selected coding.
// [R17] Mux advances after each completed conversion.
module ass_sequencer (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Configuration.
  input  wire logic        acq_start,
  input  wire logic        acq_stop,
  input  wire logic [1:0]  acq_mode,
  input  wire logic        multi_chan,
  input  wire logic        ext_conv_sel,
  input  wire logic        twos_comp,
  input  wire logic [2:0]  start_chan,
  input  wire logic [2:0]  gain_sel,
  input  wire logic [31:0] sample_interval,
  input  wire logic [31:0] scan_interval,
  input  wire logic [15:0] conv_count,
  input  wire logic        ovf_clear,
  // External convert strobe, active low.
  input  wire logic        ext_convert_n,
  // Converter side.
  output logic             adc_start,
  input  wire logic        adc_done,
  input  wire logic [11:0] adc_result,
  output logic [2:0]       mux_chan,
  output logic [2:0]       amp_gain,
  // Result read side.
  output logic             res_valid,
  input  wire logic        res_ready,
  output logic [15:0]      res_data,
  // Status.
  output logic             acq_busy,
  output logic             fifo_overflow,
  output logic             fifo_empty
);
  typedef enum logic [1:0] {
    ASS_IDLE,
    ASS_WAIT_SCAN,
    ASS_RUN
  } ass_seq_state_type;

  typedef struct packed {
    ass_seq_state_type st;
    logic [31:0]       sample_interval_counter;
    logic [31:0]       scan_interval_counter;
    logic [15:0]       conversion_count_counter;
    logic [2:0]        chan;
    logic [2:0]        gain;
    logic              conv_pend;
    logic              start_p;
    logic              ovf;
    logic              ext_q;
    logic              wr_valid;
    logic [15:0]       wr_data;
    logic              rd_valid;
    logic [15:0]       rd_data;
    logic              empty;
  } ass_seq_state_s_type;

  ass_seq_state_s_type s_q;
  ass_seq_state_s_type s_d;

  ass_stream_if #(.WIDTH(ass_pkg::FIFO_WIDTH)) res_if ();

  logic        fifo_empty_w;
  logic        fifo_rd_valid;
  logic [15:0] fifo_rd_data;
  logic        fifo_rd_ready;
  logic        sample_tick;
  logic        scan_tick;
  logic        ext_fall;
  logic        conv_tick;
  logic        last_chan;
  logic        done_count;

  // Single-entry output stage keeps res_valid and res_data on a flip-flop.
  assign fifo_rd_ready = !s_q.rd_valid || res_ready;
  assign res_if.valid  = s_q.wr_valid;
  assign res_if.data   = s_q.wr_data;

  // Timer ticks and conversion strobe selection.
  assign sample_tick = (s_q.sample_interval_counter == ass_pkg::TIMER_RESET); // R1
  assign scan_tick   = (s_q.scan_interval_counter == ass_pkg::TIMER_RESET); // R1
  assign ext_fall    = s_q.ext_q && !ext_convert_n;
  assign conv_tick   = (ext_conv_sel && ass_pkg::ass_mode_type'(acq_mode) !=
                        ass_pkg::ASS_MODE_INTERVAL) ? ext_fall : sample_tick; // R6
  assign last_chan   = !multi_chan || (s_q.chan == ass_pkg::CHAN_LAST);
  assign done_count  = (s_q.conversion_count_counter == ass_pkg::COUNT_RESET);

  // Main sequencing logic.
  always_comb begin
    s_d         = s_q;
    s_d.start_p = 1'b0;
    s_d.ext_q   = ext_convert_n;
    s_d.empty   = fifo_empty_w;
    if (fifo_rd_ready) begin
      s_d.rd_valid = fifo_rd_valid;
      s_d.rd_data  = fifo_rd_data;
    end
    if (res_if.ready) begin
      s_d.wr_valid = 1'b0;
    end
    // Result path: sign or zero extension, then push into the FIFO.
    if (adc_done) begin
      s_d.wr_valid = 1'b1;
      s_d.wr_data  = twos_comp ? {{4{adc_result[11]}}, adc_result} // R16
                               : {4'h0, adc_result}; // R16
      // Staging and output stages add two words of slack before a result is lost.
      if (s_q.wr_valid && !res_if.ready) begin
        s_d.ovf = 1'b1; // R14
      end
      // Advance the mux right after the conversion so it settles longest.
      if (multi_chan) begin
        s_d.chan = (s_q.chan == ass_pkg::CHAN_LAST) ? start_chan // R9
                                                    : s_q.chan - 3'h1; // R17
      end
    end
    if (ovf_clear && !(adc_done && s_q.wr_valid && !res_if.ready)) begin
      s_d.ovf = 1'b0;
    end
    // Sample timer reloads on every tick while running.
    if (s_q.st == ASS_RUN || s_q.st == ASS_WAIT_SCAN) begin
      s_d.sample_interval_counter = sample_tick ? sample_interval
                                                : s_q.sample_interval_counter - 32'h1;
    end
    case (s_q.st)
      ASS_IDLE: begin
        if (acq_start) begin
          s_d.chan  = multi_chan ? start_chan : start_chan; // R7
          s_d.gain  = gain_sel; // R8
          s_d.conversion_count_counter = conv_count;
          s_d.sample_interval_counter  = sample_interval;
          s_d.scan_interval_counter    = scan_interval;
          if (ass_pkg::ass_mode_type'(acq_mode) == ass_pkg::ASS_MODE_INTERVAL) begin
            s_d.st = ASS_WAIT_SCAN; // R5
          end else begin
            s_d.st = ASS_RUN;
          end
        end
      end
      ASS_WAIT_SCAN: begin
        // Scan timer runs free; the sample timer restarts at each scan pulse.
        s_d.scan_interval_counter = scan_tick ? scan_interval
                                              : s_q.scan_interval_counter - 32'h1;
        if (scan_tick) begin
          s_d.sample_interval_counter = sample_interval; // R3
          s_d.chan = multi_chan ? start_chan : s_q.chan;
          s_d.st   = ASS_RUN;
        end
      end
      ASS_RUN: begin
        if (ass_pkg::ass_mode_type'(acq_mode) == ass_pkg::ASS_MODE_INTERVAL) begin
          s_d.scan_interval_counter = scan_tick ? scan_interval
                                                : s_q.scan_interval_counter - 32'h1;
        end
        // No rate check: fast scans are converted regardless of settling.
        if (conv_tick) begin
          s_d.start_p = 1'b1; // R13
          if (ass_pkg::ass_mode_type'(acq_mode) == ass_pkg::ASS_MODE_CONTROLLED) begin
            s_d.conversion_count_counter = s_q.conversion_count_counter - 16'h1;
            if (s_q.conversion_count_counter == 16'h1) begin
              s_d.st = ASS_IDLE; // R15
            end
          end
          if (ass_pkg::ass_mode_type'(acq_mode) == ass_pkg::ASS_MODE_INTERVAL &&
              last_chan) begin
            s_d.st = ASS_WAIT_SCAN; // R2
          end
        end
        if (ass_pkg::ass_mode_type'(acq_mode) == ass_pkg::ASS_MODE_CONTROLLED &&
            done_count) begin
          s_d.st = ASS_IDLE; // R15
        end
      end
      default: begin
        s_d.st = ASS_IDLE;
      end
    endcase
    if (acq_stop) begin
      s_d.st = ASS_IDLE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q       <= '0;
      s_q.st    <= ASS_IDLE;
      s_q.ext_q <= 1'b1;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ass_fifo #(
    .WIDTH(ass_pkg::FIFO_WIDTH),
    .DEPTH(ass_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wr       (res_if),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data),
    .full     (),
    .empty    (fifo_empty_w)
  );

  // Outputs straight from flip-flops, except acq_busy, which is decoded from the state.
  assign adc_start     = s_q.start_p;
  assign mux_chan      = s_q.chan;
  assign amp_gain      = s_q.gain;
  assign res_valid     = s_q.rd_valid;
  assign res_data      = s_q.rd_data;
  assign acq_busy      = (s_q.st != ASS_IDLE);
  assign fifo_overflow = s_q.ovf;
  assign fifo_empty    = s_q.empty;

  // Checks on sequencing behaviour.
  sequence scan_pulse_s;
    s_q.st == ASS_WAIT_SCAN && scan_tick && !acq_stop;
  endsequence

  sequence run_entered_s;
    s_q.st == ASS_RUN;
  endsequence

  first_delay_a: assert property (@(posedge sys_clk) disable iff (rst) // R3
    scan_pulse_s ##1 run_entered_s |-> !adc_start ##1 !adc_start)
    else $error("Conversion started right after scan pulse.");

  mux_wrap_a: assert property (@(posedge sys_clk) disable iff (rst) // R9
    adc_done && multi_chan && s_q.chan == 3'h0 |=> s_q.chan == $past(start_chan))
    else $error("Channel did not reload start channel.");

  mux_step_a: assert property (@(posedge sys_clk) disable iff (rst) // R17
    adc_done && multi_chan && s_q.chan != 3'h0 |=> s_q.chan == $past(s_q.chan) - 3'h1)
    else $error("Channel did not step down after conversion.");

  sign_ext_a: assert property (@(posedge sys_clk) disable iff (rst) // R16
    adc_done && twos_comp |=> s_q.wr_data[15:12] == {4{$past(adc_result[11])}})
    else $error("Result not sign extended.");

  zero_ext_a: assert property (@(posedge sys_clk) disable iff (rst) // R16
    adc_done && !twos_comp |=> s_q.wr_data[15:12] == 4'h0)
    else $error("Straight binary result not zero extended.");

  overflow_set_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
    adc_done && s_q.wr_valid && !res_if.ready |=> fifo_overflow)
    else $error("Overflow not flagged on full FIFO.");

  gain_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R8
    s_q.st == ASS_RUN && !acq_start |=> amp_gain == $past(amp_gain))
    else $error("Gain changed during a scan.");

  count_stop_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
    s_q.st == ASS_RUN && acq_mode == 2'h1 &&
    (done_count || (conv_tick && s_q.conversion_count_counter == 16'h1)) |=> !acq_busy)
    else $error("Acquisition ran past its conversion count.");

  conv_pace_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
    s_q.st == ASS_RUN && sample_tick && !ext_conv_sel |=> adc_start)
    else $error("Sample tick did not start a conversion.");

  scan_wait_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    s_q.st == ASS_WAIT_SCAN |-> !adc_start || $past(s_q.st) == ASS_RUN)
    else $error("Conversion while waiting for scan interval.");

  ovf_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
    fifo_overflow && !ovf_clear |=> fifo_overflow)
    else $error("Overflow flag dropped without a clear.");

  ext_only_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
    s_q.st == ASS_RUN && ext_conv_sel && acq_mode != 2'h2 && !ext_fall |=> !adc_start)
    else $error("Conversion started without an external convert edge.");

  chan_fixed_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
    s_q.st != ASS_IDLE && !multi_chan |=> $stable(mux_chan))
    else $error("Channel moved during a single-channel acquisition.");

  scan_reload_a: assert property (@(posedge sys_clk) disable iff (rst) // R3
    scan_pulse_s |=> s_q.sample_interval_counter == $past(sample_interval))
    else $error("Sample timer not restarted at the scan pulse.");
endmodule

/* File: test/ass_adc_model.sv */
// Behavioural converter model that answers each start pulse after a set delay.
`timescale 1ns/1ps
module ass_adc_model (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Start and channel from the sequencer.
  input  wire logic        adc_start,
  input  wire logic [2:0]  mux_chan,
  // Conversion time in cycles, prompt or slow.
  input  wire logic [7:0]  lat,
  // Result back to the sequencer.
  output logic             adc_done,
  output logic [11:0]      adc_result
);
  logic [7:0]  cnt_q;
  logic [11:0] val_q;

  // Latch the channel at start so a late mux step cannot alter the value.
  // Outside done the result lines flip every cycle, so a stale read shows.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q      <= 8'h00;
      val_q      <= 12'h000;
      adc_done   <= 1'b0;
      adc_result <= 12'h000;
    end else begin
      adc_done   <= 1'b0;
      adc_result <= ~adc_result;
      if (adc_start) begin
        cnt_q <= lat;
        val_q <= {mux_chan[0], 8'h5a, mux_chan};
      end else if (cnt_q == 8'h01) begin
        cnt_q      <= 8'h00;
        adc_done   <= 1'b1;
        adc_result <= val_q;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

/* File: test/ass_sequencer_bench.sv */
// Self-checking bench for the scan sequencer with a converter model.
`timescale 1ns/1ps
module ass_sequencer_bench;
  logic        sys_clk, rst, acq_start, acq_stop, multi_chan, ext_conv_sel, twos_comp;
  logic        ovf_clear, ext_convert_n, adc_start, adc_done, res_valid, res_ready;
  logic        acq_busy, fifo_overflow, fifo_empty;
  logic [1:0]  acq_mode;
  logic [2:0]  start_chan, gain_sel, mux_chan, amp_gain;
  logic [7:0]  lat;
  logic [11:0] adc_result;
  logic [15:0] conv_count, res_data;
  logic [31:0] sample_interval, scan_interval;
  int          n_mismatch, checks, cyc, t0, i;
  int          st_t[$];
  logic [2:0]  st_ch[$], st_g[$];
  logic [15:0] rd_q[$];

  ass_sequencer u_ass_sequencer (.sys_clk, .rst, .acq_start, .acq_stop, .acq_mode,
    .multi_chan, .ext_conv_sel, .twos_comp, .start_chan, .gain_sel, .sample_interval,
    .scan_interval, .conv_count, .ovf_clear, .ext_convert_n, .adc_start, .adc_done,
    .adc_result, .mux_chan, .amp_gain, .res_valid, .res_ready, .res_data, .acq_busy,
    .fifo_overflow, .fifo_empty);
  ass_adc_model u_ass_adc_model (.sys_clk, .rst, .adc_start, .mux_chan, .lat, .adc_done,
    .adc_result);

  // Free-running 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Logs each conversion start and each word taken from the result stream.
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (!rst && adc_start) begin
      st_t.push_back(cyc);
      st_ch.push_back(mux_chan);
      st_g.push_back(amp_gain);
    end
    if (!rst && res_valid && res_ready) rd_q.push_back(res_data);
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp);
    checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The model codes the channel into the result; bit 11 follows channel bit 0.
  function automatic logic [15:0] exp_word(input logic [2:0] ch, input logic tc);
    logic [11:0] r;
    r = {ch[0], 8'h5a, ch};
    return tc ? {{4{r[11]}}, r} : {4'h0, r};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Loads the whole setup and pulses start; t0 is the edge that took it.
  task automatic run(input logic [1:0] md, input logic mc, ex, tc, input logic [2:0] ch, g,
                     input logic [31:0] si, sc, input logic [15:0] cnt);
    acq_mode = md;
    multi_chan = mc;
    ext_conv_sel = ex;
    twos_comp = tc;
    start_chan = ch;
    gain_sel = g;
    sample_interval = si;
    scan_interval = sc;
    conv_count = cnt;
    st_t.delete();
    st_ch.delete();
    st_g.delete();
    rd_q.delete();
    acq_start = 1'b1;
    tick(1);
    acq_start = 1'b0;
    t0 = cyc;
  endtask

  task automatic wait_starts(input int n);
    for (int k = 0; k < 30000 && st_t.size() < n; k++) tick(1);
    chk_num(st_t.size() >= n, 1);
  endtask

  // Stops if do_stop is set, then lets the stream run dry; a bounded loop guards each wait.
  task automatic stop_drain(input logic do_stop);
    if (do_stop) begin
      acq_stop = 1'b1;
      tick(1);
      acq_stop = 1'b0;
    end
    for (int k = 0; k < 2000 && acq_busy !== 1'b0; k++) tick(1);
    // The last conversion may still be in flight when busy drops, so let it land first.
    tick(32);
    res_ready = 1'b1;
    for (int k = 0; k < 3000 && !(fifo_empty === 1'b1 && res_valid === 1'b0); k++) tick(1);
    tick(4);
  endtask

  // Watchdog sized well above the roughly 7000 cycles the tests need.
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    {acq_start, acq_stop, multi_chan, ext_conv_sel, twos_comp, ovf_clear} = 6'h00;
    {acq_mode, start_chan, gain_sel, conv_count} = 24'h000000;
    {sample_interval, scan_interval} = 64'h0;
    {n_mismatch, checks, cyc} = 0;
    rst = 1'b1;
    ext_convert_n = 1'b1;
    res_ready = 1'b1;
    lat = 8'h04;
    tick(16);
    chk_bit(adc_start | acq_busy | res_valid | fifo_overflow, 1'b0);
    chk_bit(fifo_empty, 1'b1);
    rst = 1'b0;
    tick(2);
    // Controlled multichannel scan, count six, sample interval above conversion time.
    run(2'h1, 1'b1, 1'b0, 1'b1, 3'h3, 3'h5, 32'h13, 32'h0, 16'h0006);
    stop_drain(1'b0);
    chk_num(st_t.size(), 6);
    chk_bit(acq_busy, 1'b0);
    for (i = 0; i < 6; i++) begin
      chk_word({13'h0000, st_ch[i]}, 16'(3 - i % 4));
      chk_word({13'h0000, st_g[i]}, 16'h0005);
      chk_word(rd_q[i], exp_word(3'(3 - i % 4), 1'b1));
      if (i > 0) chk_num(st_t[i] - st_t[i-1], 20);
    end
    // Freerun single channel at the converter limit, straight binary.
    lat = 8'h03;
    run(2'h0, 1'b0, 1'b0, 1'b0, 3'h6, 3'h2, 32'h9, 32'h0, 16'h0000);
    wait_starts(5);
    stop_drain(1'b1);
    for (i = 0; i < 4; i++) begin
      chk_word({10'h000, st_g[i], st_ch[i]}, 16'h0016);
      chk_word(rd_q[i], exp_word(3'h6, 1'b0));
      chk_num(st_t[i+1] - st_t[i], 10);
    end
    // Interval scanning over three channels with a slow converter.
    lat = 8'h0c;
    run(2'h2, 1'b1, 1'b0, 1'b1, 3'h2, 3'h1, 32'he, 32'hc7, 16'h0000);
    wait_starts(6);
    stop_drain(1'b1);
    chk_num(st_t[0] - t0 >= 215 && st_t[0] - t0 <= 217, 1);
    chk_num(st_t[3] - st_t[0], 200);
    for (i = 0; i < 6; i++) begin
      chk_word({13'h0000, st_ch[i]}, 16'(2 - i % 3));
      if (i % 3 != 0) chk_num(st_t[i] - st_t[i-1], 15);
    end
    // Interval scanning on one channel.
    run(2'h2, 1'b0, 1'b0, 1'b1, 3'h4, 3'h1, 32'he, 32'h63, 16'h0000);
    wait_starts(2);
    stop_drain(1'b1);
    chk_word({10'h000, st_ch[0], st_ch[1]}, 16'h0024);
    // External convert: one conversion per falling edge, even when held low.
    run(2'h0, 1'b0, 1'b1, 1'b1, 3'h1, 3'h0, 32'h3e7, 32'h0, 16'h0000);
    repeat (3) begin
      ext_convert_n = 1'b0;
      tick(3);
      ext_convert_n = 1'b1;
      tick(30);
    end
    chk_num(st_t.size(), 3);
    chk_word({10'h000, st_ch[0], st_ch[2]}, 16'h0009);
    stop_drain(1'b1);
    // Fill with the reader stalled until results are lost, then clear and drain.
    lat = 8'h03;
    res_ready = 1'b0;
    run(2'h0, 1'b0, 1'b0, 1'b1, 3'h7, 3'h0, 32'h9, 32'h0, 16'h0000);
    wait_starts(530);
    acq_stop = 1'b1;
    tick(1);
    acq_stop = 1'b0;
    tick(10);
    chk_bit(fifo_overflow, 1'b1);
    ovf_clear = 1'b1;
    tick(1);
    ovf_clear = 1'b0;
    tick(1);
    chk_bit(fifo_overflow, 1'b0);
    stop_drain(1'b0);
    chk_num(rd_q.size() >= 512 && rd_q.size() <= 516, 1);
    chk_word(rd_q[0], exp_word(3'h7, 1'b1));
    chk_bit(fifo_empty, 1'b1);
    summarize();
  end
endmodule
